// *** seq_step_ctrl.sv ***
// Step sequencer: step table, run state machine, branch inputs and register port
`timescale 1ns/1ps
module seq_step_ctrl
	import seq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [seq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [seq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [seq_pkg::DATA_W-1:0] reg_rdata,
	// Branch pins and phase indication
	input wire logic level_branch,
	input wire logic edge_branch,
	input wire logic phase_at_stop,
	// Sequencer outputs
	output logic [seq_pkg::STEP_W-1:0] cur_step,
	output logic [seq_pkg::SHAPE_W-1:0] wave_shape,
	output logic [seq_pkg::CODE_W-1:0] step_sync_code,
	output logic [seq_pkg::NUM_PARAMS*seq_pkg::VAL_W-1:0] param_value
);
	logic [DUR_W-1:0] step_dur [NUM_STEPS];
	logic [DATA_W-1:0] step_ctrl [NUM_STEPS];
	logic [VAL_W-1:0] step_target [NUM_STEPS][NUM_PARAMS];
	logic [STEP_W-1:0] sel;

	seq_state_t state;
	seq_state_t next_state;
	logic [STEP_W-1:0] next_step;
	logic [DUR_W-1:0] elapsed;
	logic [DUR_W-1:0] next_elapsed;
	logic ran;
	logic next_ran;
	logic load;
	logic advance;
	logic [STEP_W-1:0] load_step;
	logic [DATA_W-1:0] load_ctrl;
	logic [DUR_W-1:0] load_dur;
	logic [DATA_W-1:0] act_ctrl;
	logic [DUR_W-1:0] act_dur;
	logic [SHAPE_W-1:0] next_shape;
	logic [CODE_W-1:0] next_code;

	logic [2:0] lvl_sync;
	logic [2:0] edg_sync;
	logic lvl_stable;
	logic edg_stable;
	logic edge_hit;

	logic cmd_start;
	logic cmd_stop;
	logic cmd_resume;
	logic cmd_edge;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] ctrl_wr;
	logic [ACT_W-1:0] act_field;

	assign cmd_start = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_START];
	assign cmd_stop = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_STOP];
	assign cmd_resume = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_RESUME];
	assign cmd_edge = reg_wr && (reg_addr == REG_CMD) && reg_wdata[CMD_EDGE];

	// Pin synchronisers; a level counts once the second and third stages agree
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			lvl_sync <= 3'h0;
			edg_sync <= 3'h0;
			lvl_stable <= 1'b0;
			edg_stable <= 1'b0;
		end
		else
		begin
			lvl_sync <= {lvl_sync[1:0], level_branch};
			edg_sync <= {edg_sync[1:0], edge_branch};
			if (lvl_sync[1] == lvl_sync[2])
				lvl_stable <= lvl_sync[2];
			if (edg_sync[1] == edg_sync[2])
				edg_stable <= edg_sync[2];
		end
	end

	assign edge_hit = (edg_sync[1] && edg_sync[2] && !edg_stable) || cmd_edge;
	assign act_ctrl = step_ctrl[cur_step];
	assign act_dur = (step_dur[cur_step] == '0) ? DUR_MIN : step_dur[cur_step];
	assign load_ctrl = step_ctrl[load_step];
	assign load_dur = (step_dur[load_step] == '0) ? DUR_MIN : step_dur[load_step];

	// Step table writes; keep is turned into constant for step 0
	always_comb
	begin
		ctrl_wr = reg_wdata;
		for (int p = 0; p < NUM_PARAMS; p++)
		begin
			act_field = reg_wdata[F_ACT+p*ACT_W +: ACT_W];
			if (sel == STEP_ZERO && act_field == ACT_KEEP)
				ctrl_wr[F_ACT+p*ACT_W +: ACT_W] = ACT_CONST;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			sel <= STEP_ZERO;
			for (int s = 0; s < NUM_STEPS; s++)
			begin
				step_dur[s] <= DUR_RESET;
				step_ctrl[s] <= CTRL_RESET;
				for (int p = 0; p < NUM_PARAMS; p++)
					step_target[s][p] <= VAL_RESET;
			end
		end
		else if (reg_wr)
		begin
			if (reg_addr == REG_STEP_SEL)
				sel <= reg_wdata[STEP_W-1:0];
			else if (reg_addr == REG_STEP_DUR)
				step_dur[sel] <= reg_wdata;
			else if (reg_addr == REG_STEP_CTRL)
				step_ctrl[sel] <= ctrl_wr;
			else
			begin
				for (int p = 0; p < NUM_PARAMS; p++)
					if (reg_addr == REG_TARGET0 + ADDR_W'(p) * REG_STRIDE)
						step_target[sel][p] <= reg_wdata[VAL_W-1:0];
			end
		end
	end

	// Run state machine
	always_comb
	begin
		next_state = state;
		next_step = cur_step;
		next_elapsed = elapsed;
		next_ran = ran;
		load = 1'b0;
		load_step = cur_step;
		advance = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (cmd_start)
				begin
					next_ran = 1'b1;
					load = 1'b1;
					load_step = STEP_ONE;
				end
				else if (!ran)
				begin
					load = 1'b1;
					load_step = STEP_ZERO;
				end
			end
			ST_RUN, ST_END0:
			begin
				if (state == ST_RUN && edge_hit && act_ctrl[F_EDGE_EN])
				begin
					load = 1'b1;
					load_step = act_ctrl[F_EDGE_TGT +: STEP_W];
				end
				else if (state == ST_RUN && cmd_stop)
				begin
					load = 1'b1;
					load_step = STEP_ZERO;
				end
				else if (elapsed < act_dur)
				begin
					advance = 1'b1;
					next_elapsed = elapsed + DUR_MIN;
				end
				else if (state == ST_END0)
					next_state = ST_IDLE;
				else if (act_ctrl[F_PHASE] && !phase_at_stop)
					next_state = ST_PHASE;
				else if (act_ctrl[F_HOLD])
					next_state = ST_HOLD;
				else if (act_ctrl[F_LEVEL_EN] && lvl_stable)
				begin
					load = 1'b1;
					load_step = act_ctrl[F_LEVEL_TGT +: STEP_W];
				end
				else
				begin
					load = 1'b1;
					if (act_ctrl[F_TERM_END] || cur_step == STEP_LAST)
						load_step = STEP_ZERO;
					else
						load_step = cur_step + STEP_ONE;
				end
			end
			ST_PHASE:
			begin
				if (edge_hit && act_ctrl[F_EDGE_EN])
				begin
					load = 1'b1;
					load_step = act_ctrl[F_EDGE_TGT +: STEP_W];
				end
				else if (phase_at_stop)
					next_state = ST_RUN;
			end
			ST_HOLD:
			begin
				if (edge_hit && act_ctrl[F_EDGE_EN])
				begin
					load = 1'b1;
					load_step = act_ctrl[F_EDGE_TGT +: STEP_W];
				end
				else if (cmd_stop)
				begin
					load = 1'b1;
					load_step = STEP_ZERO;
				end
				else if (cmd_resume)
				begin
					load = 1'b1;
					if (act_ctrl[F_TERM_END] || cur_step == STEP_LAST)
						load_step = STEP_ZERO;
					else if (act_ctrl[F_LEVEL_EN] && lvl_stable)
						load_step = act_ctrl[F_LEVEL_TGT +: STEP_W];
					else
						load_step = cur_step + STEP_ONE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
		if (load && state != ST_IDLE)
		begin
			next_step = load_step;
			next_elapsed = '0;
			next_state = (load_step == STEP_ZERO) ? ST_END0 : ST_RUN;
		end
		else if (load && cmd_start)
		begin
			next_step = load_step;
			next_elapsed = '0;
			next_state = ST_RUN;
		end
		next_shape = load ? load_ctrl[F_SHAPE +: SHAPE_W] : wave_shape;
		next_code = load ? load_ctrl[F_CODE +: CODE_W] : step_sync_code;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state <= ST_IDLE;
			cur_step <= STEP_ZERO;
			elapsed <= '0;
			ran <= 1'b0;
			wave_shape <= '0;
			step_sync_code <= '0;
		end
		else
		begin
			state <= next_state;
			cur_step <= next_step;
			elapsed <= next_elapsed;
			ran <= next_ran;
			wave_shape <= next_shape;
			step_sync_code <= next_code;
		end
	end

	// Per-parameter value engines; step 0 before the first start loads as constant
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PARAMS; gp++)
		begin : g_param
			logic [ACT_W-1:0] act;
			assign act = (state == ST_IDLE && !cmd_start) ? ACT_CONST : load_ctrl[F_ACT+gp*ACT_W +: ACT_W];
			param_ramp u_ramp (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.load(load),
				.action(act),
				.target(step_target[load_step][gp]),
				.dur(act_dur),
				.elapsed(next_elapsed),
				.advance(advance),
				.value(param_value[gp*VAL_W +: VAL_W])
			);
		end
	endgenerate

	// Register reads, answered the cycle after the strobe
	always_comb
	begin
		next_rdata = '0;
		if (reg_rd)
		begin
			if (reg_addr == REG_STATUS)
			begin
				next_rdata[S_STEP +: STEP_W] = cur_step;
				next_rdata[S_STATE +: 5] = state;
				next_rdata[S_RAN] = ran;
			end
			else if (reg_addr == REG_STEP_SEL)
				next_rdata[STEP_W-1:0] = sel;
			else if (reg_addr == REG_STEP_DUR)
				next_rdata = step_dur[sel];
			else if (reg_addr == REG_STEP_CTRL)
				next_rdata = step_ctrl[sel];
			else
			begin
				for (int p = 0; p < NUM_PARAMS; p++)
				begin
					if (reg_addr == REG_TARGET0 + ADDR_W'(p) * REG_STRIDE)
						next_rdata[VAL_W-1:0] = step_target[sel][p];
					if (reg_addr == REG_VALUE0 + ADDR_W'(p) * REG_STRIDE)
						next_rdata[VAL_W-1:0] = param_value[p*VAL_W +: VAL_W];
				end
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			reg_rdata <= '0;
		else
			reg_rdata <= next_rdata;
	end
endmodule

// *** seq_pkg.sv ***
// Shared constants, register map and types of the step sequencer
package seq_pkg;
	localparam int STEP_W = 4;
	localparam int NUM_STEPS = 16;
	localparam int NUM_PARAMS = 3;
	localparam int VAL_W = 16;
	localparam int DUR_W = 32;
	localparam int ACT_W = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STEP_SEL = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STEP_DUR = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_STEP_CTRL = 8'h10;
	localparam logic [ADDR_W-1:0] REG_TARGET0 = 8'h14;
	localparam logic [ADDR_W-1:0] REG_VALUE0 = 8'h20;
	localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;

	// Command register bits
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_RESUME = 2;
	localparam int CMD_EDGE = 3;

	// Step control word fields
	localparam int F_HOLD = 0;
	localparam int F_TERM_END = 1;
	localparam int F_PHASE = 2;
	localparam int F_LEVEL_EN = 3;
	localparam int F_EDGE_EN = 4;
	localparam int F_LEVEL_TGT = 8;
	localparam int F_EDGE_TGT = 12;
	localparam int F_CODE = 16;
	localparam int F_SHAPE = 20;
	localparam int F_ACT = 24;
	localparam int CODE_W = 4;
	localparam int SHAPE_W = 4;

	// Status register fields
	localparam int S_STEP = 0;
	localparam int S_STATE = 8;
	localparam int S_RAN = 16;

	localparam logic [ACT_W-1:0] ACT_CONST = 2'h0;
	localparam logic [ACT_W-1:0] ACT_KEEP = 2'h1;
	localparam logic [ACT_W-1:0] ACT_RAMP = 2'h2;

	localparam logic [STEP_W-1:0] STEP_ZERO = 4'h0;
	localparam logic [STEP_W-1:0] STEP_ONE = 4'h1;
	localparam logic [STEP_W-1:0] STEP_LAST = 4'hf;
	localparam logic [DUR_W-1:0] DUR_MIN = 32'h00000001;
	localparam logic [DUR_W-1:0] DUR_RESET = 32'h00000001;
	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h00000000;
	localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_RUN = 5'b00010,
		ST_PHASE = 5'b00100,
		ST_HOLD = 5'b01000,
		ST_END0 = 5'b10000
	} seq_state_t;
endpackage

// *** param_ramp.sv ***
// One output parameter: constant, keep or linear ramp within a step
`timescale 1ns/1ps
module param_ramp
	import seq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Step entry and progress
	input wire logic load,
	input wire logic [seq_pkg::ACT_W-1:0] action,
	input wire logic [seq_pkg::VAL_W-1:0] target,
	input wire logic [seq_pkg::DUR_W-1:0] dur,
	input wire logic [seq_pkg::DUR_W-1:0] elapsed,
	input wire logic advance,
	// Current value
	output logic [seq_pkg::VAL_W-1:0] value
);
	logic [VAL_W-1:0] start_val;
	logic [VAL_W-1:0] end_val;
	logic ramping;
	logic [VAL_W-1:0] next_value;
	logic [VAL_W-1:0] next_start_val;
	logic [VAL_W-1:0] next_end_val;
	logic next_ramping;
	logic signed [VAL_W:0] diff;
	logic signed [VAL_W+DUR_W+1:0] prod;
	logic signed [VAL_W+DUR_W+1:0] quo;

	always_comb
	begin
		next_value = value;
		next_start_val = start_val;
		next_end_val = end_val;
		next_ramping = ramping;
		diff = $signed({1'b0, end_val}) - $signed({1'b0, start_val});
		prod = (VAL_W+DUR_W+2)'(diff) * $signed({2'b00, elapsed});
		quo = prod / $signed({(VAL_W+2)'(0), dur});
		if (load)
		begin
			next_ramping = (action == ACT_RAMP);
			next_start_val = value;
			next_end_val = target;
			if (action == ACT_CONST)
				next_value = target;
		end
		else if (advance && ramping)
		begin
			if (elapsed >= dur)
				next_value = end_val;
			else
				next_value = VAL_W'($signed({1'b0, start_val}) + quo[VAL_W:0]);
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			value <= VAL_RESET;
			start_val <= VAL_RESET;
			end_val <= VAL_RESET;
			ramping <= 1'b0;
		end
		else
		begin
			value <= next_value;
			start_val <= next_start_val;
			end_val <= next_end_val;
			ramping <= next_ramping;
		end
	end
endmodule

// *** seq_step_ctrl_assertions.sv ***
// Port-level checks of the step sequencer
`timescale 1ns/1ps
module seq_step_ctrl_checker
	import seq_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Register port
	input wire logic [seq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [seq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [seq_pkg::DATA_W-1:0] reg_rdata,
	// Sequencer outputs
	input wire logic [seq_pkg::STEP_W-1:0] cur_step,
	input wire logic [seq_pkg::NUM_PARAMS*seq_pkg::VAL_W-1:0] param_value
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_reset_idle: assert property ($past(sys_rst) |-> cur_step == STEP_ZERO && param_value == 48'h0)
		else $error("state after reset not idle");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
	a_cmd_reads_zero: assert property (reg_rd && reg_addr == REG_CMD |=> reg_rdata == 32'h0)
		else $error("command register read not zero");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'hfc |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_status_step: assert property (reg_rd && reg_addr == REG_STATUS |=> reg_rdata[3:0] == $past(cur_step))
		else $error("status step differs from current step");
	a_live_value: assert property (reg_rd && reg_addr == REG_VALUE0 |=> reg_rdata[15:0] == $past(param_value[15:0]))
		else $error("live value read differs from output");
	a_leave_zero: assert property ($past(cur_step) == STEP_ZERO && cur_step != STEP_ZERO |-> cur_step == STEP_ONE)
		else $error("step zero left to a step other than one");
	a_sel_readback: assert property (reg_wr && reg_addr == REG_STEP_SEL ##1 reg_rd && reg_addr == REG_STEP_SEL
		|=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
		else $error("step select readback wrong");
endmodule

bind seq_step_ctrl seq_step_ctrl_checker chk (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .cur_step, .param_value);

// *** branch_source.sv ***
// Operator-side model driving the branch pins and the phase indication
`timescale 1ns/1ps
module branch_source
(
	// Clock, reset and bench requests
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic fire,
	input wire logic level_req,
	input wire logic phase_wait_req,
	// Pins of the sequencer
	output logic edge_branch,
	output logic level_branch,
	output logic phase_at_stop
);
	logic [3:0] pulse;
	// Four-cycle edge so the input synchroniser cannot miss it
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst || fire)
			pulse <= {4{fire}};
		else
			pulse <= {pulse[2:0], 1'b0};
	end
	assign edge_branch = pulse[3];
	assign level_branch = level_req;
	// Reference phase reported away from the end phase while the bench asks for a wait
	assign phase_at_stop = !phase_wait_req;
endmodule

// *** seq_step_ctrl_tb.sv ***
// Self-checking bench of the step sequencer
`timescale 1ns/1ps
module seq_step_ctrl_tb;
	import seq_pkg::*;
	logic clk_sys, sys_rst, reg_wr, reg_rd, fire, level_req, phase_wait_req;
	logic edge_branch, level_branch, phase_at_stop;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, got;
	logic [3:0] cur_step, wave_shape, step_sync_code;
	logic [47:0] param_value;
	int miscompares = 0;
	int checks_done = 0;

	seq_step_ctrl uut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .level_branch,
		.edge_branch, .phase_at_stop, .cur_step, .wave_shape, .step_sync_code, .param_value);
	branch_source ops (.clk_sys, .sys_rst, .fire, .level_req, .phase_wait_req, .edge_branch, .level_branch,
		.phase_at_stop);

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		// Idle edge so a following write never lowers and raises the strobe in one step
		@(posedge clk_sys);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		got = reg_rdata;
		chk(e, got);
	endtask

	task automatic cfg(input logic [3:0] s, input logic [31:0] dur, input logic [31:0] ctrl, input logic [15:0] t);
		wr(REG_STEP_SEL, {28'h0, s});
		wr(REG_STEP_DUR, dur);
		wr(REG_STEP_CTRL, ctrl);
		wr(REG_TARGET0, {16'h0, t});
	endtask

	task automatic wait_step(input logic [3:0] s, input int lim);
		int n;
		n = 0;
		while (cur_step !== s && n < lim)
		begin
			@(posedge clk_sys);
			n++;
		end
		chk({28'h0, s}, {28'h0, cur_step});
	endtask

	// Times one step and checks its second-cycle and final value of parameter 0
	task automatic watch(input int dur, input logic [15:0] midv, input logic [15:0] endv);
		logic [3:0] s;
		logic [15:0] last;
		int n;
		s = cur_step;
		n = 0;
		while (cur_step === s && n < 300)
		begin
			if (n == 1)
				chk({16'h0, midv}, {16'h0, param_value[15:0]});
			last = param_value[15:0];
			@(posedge clk_sys);
			n++;
		end
		chk({16'h0, endv}, {16'h0, last});
		chk(32'h1, {31'h0, n >= dur + 1 && n <= dur + 2});
	endtask

	task automatic test_idle();
		chk(32'h0, {28'h0, cur_step});
		rdchk(REG_STATUS, 32'h00000100);
		rdchk(REG_VALUE0, 32'h0);
		rdchk(REG_CMD, 32'h0);
		rdchk(8'hfc, 32'h0);
		// Write and read back the step select with no gap between the strobes
		reg_addr <= REG_STEP_SEL;
		reg_wdata <= 32'h5;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(posedge clk_sys);
		got = reg_rdata;
		chk(32'h5, got);
		wr(REG_STEP_SEL, 32'h0);
		rdchk(REG_STEP_SEL, 32'h0);
		wr(REG_STEP_CTRL, 32'h01000000);
		rdchk(REG_STEP_CTRL, 32'h0);
		cfg(STEP_ZERO, 32'h4, 32'h02000000, 16'h20);
		repeat (2) @(posedge clk_sys);
		rdchk(REG_VALUE0, 32'h20);
		$display("test_idle done");
	endtask

	task automatic test_run_end();
		cfg(4'h1, 32'h4, 32'h02000000, 16'h40);
		cfg(4'h2, 32'h3, 32'h01000000, 16'h0);
		cfg(4'h3, 32'h2, 32'h003a0003, 16'h10);
		wr(REG_CMD, 32'h1);
		wait_step(STEP_ONE, 2);
		watch(4, 16'h28, 16'h40);
		chk(32'h2, {28'h0, cur_step});
		watch(3, 16'h40, 16'h40);
		chk(32'h3, {28'h0, cur_step});
		@(posedge clk_sys);
		chk(32'h10, {16'h0, param_value[15:0]});
		repeat (12) @(posedge clk_sys);
		chk(32'h3, {28'h0, cur_step});
		chk(32'h3a, {24'h0, wave_shape, step_sync_code});
		rdchk(REG_VALUE0, 32'h10);
		wr(REG_CMD, 32'h4);
		wait_step(STEP_ZERO, 2);
		repeat (12) @(posedge clk_sys);
		rdchk(REG_STATUS, 32'h00010100);
		rdchk(REG_VALUE0, 32'h20);
		$display("test_run_end done");
	endtask

	task automatic test_resume();
		cfg(4'h3, 32'h2, 32'h00000001, 16'h10);
		cfg(4'h4, 32'h2, 32'h00000002, 16'h55);
		wr(REG_CMD, 32'h1);
		wait_step(STEP_ONE, 2);
		wait_step(4'h3, 20);
		repeat (6) @(posedge clk_sys);
		wr(REG_CMD, 32'h4);
		wait_step(4'h4, 2);
		wait_step(STEP_ZERO, 6);
		repeat (12) @(posedge clk_sys);
		$display("test_resume done");
	endtask

	task automatic test_level_stop();
		cfg(4'h1, 32'h6, 32'h02000308, 16'h40);
		level_req <= 1'b1;
		wr(REG_CMD, 32'h1);
		wait_step(STEP_ONE, 2);
		watch(6, 16'h25, 16'h40);
		chk(32'h3, {28'h0, cur_step});
		repeat (6) @(posedge clk_sys);
		wr(REG_CMD, 32'h2);
		wait_step(STEP_ZERO, 2);
		level_req <= 1'b0;
		repeat (12) @(posedge clk_sys);
		$display("test_level_stop done");
	endtask

	task automatic test_edge();
		cfg(4'h1, 32'h4, 32'h02003014, 16'h40);
		phase_wait_req <= 1'b1;
		wr(REG_CMD, 32'h1);
		wait_step(STEP_ONE, 2);
		repeat (8) @(posedge clk_sys);
		chk(32'h1, {28'h0, cur_step});
		chk(32'h40, {16'h0, param_value[15:0]});
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
		wait_step(4'h3, 10);
		phase_wait_req <= 1'b0;
		repeat (6) @(posedge clk_sys);
		wr(REG_CMD, 32'h2);
		wait_step(STEP_ZERO, 2);
		$display("test_edge done");
	endtask

	task automatic test_reset();
		repeat (12) @(posedge clk_sys);
		wr(REG_CMD, 32'h1);
		wait_step(STEP_ONE, 2);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk(32'h0, {28'h0, cur_step});
		rdchk(REG_STATUS, 32'h00000100);
		rdchk(REG_STEP_DUR, 32'h1);
		rdchk(REG_VALUE0, 32'h0);
		$display("test_reset done");
	endtask

	initial
	begin
		#20000;
		miscompares++;
		give_verdict();
	end

	initial
	begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		fire = 1'b0;
		level_req = 1'b0;
		phase_wait_req = 1'b0;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		test_idle();
		test_run_end();
		test_resume();
		test_level_stop();
		test_edge();
		test_reset();
		give_verdict();
	end
endmodule
